// file: hw/mssj_pkg.sv
package mssj_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_MHZ * 1000 * TICK_MS;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_CMP_THR = 12'h004;
  localparam logic [11:0] ADDR_NEAR_THR = 12'h008;
  localparam logic [11:0] ADDR_WINDOW = 12'h00C;
  localparam logic [11:0] ADDR_HOLD = 12'h010;
  localparam logic [11:0] ADDR_ROT_THR = 12'h014;
  localparam logic [11:0] ADDR_CONS_THR = 12'h018;
  localparam logic [11:0] ADDR_APPR_THR = 12'h01C;
  localparam logic [11:0] ADDR_ZERO_THR = 12'h020;
  localparam logic [11:0] ADDR_TQ_THR = 12'h024;
  localparam logic [11:0] ADDR_TQ_HYS = 12'h028;
  localparam logic [11:0] ADDR_STATUS = 12'h02C;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_CMP_THR = 16'h0320;
  localparam logic [15:0] RST_NEAR_THR = 16'h1388;
  localparam logic [15:0] RST_WINDOW = 16'h000A;
  localparam logic [15:0] RST_HOLD = 16'h0064;
  localparam logic [15:0] RST_ROT_THR = 16'h0014;
  localparam logic [15:0] RST_CONS_THR = 16'h000A;
  localparam logic [15:0] RST_APPR_THR = 16'h0064;
  localparam logic [15:0] RST_ZERO_THR = 16'h000A;
  localparam logic [15:0] RST_TQ_THR = 16'h0064;
  localparam logic [15:0] RST_TQ_HYS = 16'h000A;
  localparam logic [15:0] CONS_MAX = 16'h0064;
  localparam logic [15:0] HYS_MIN = 16'h000A;
  localparam logic [15:0] HYS_MAX = 16'h0014;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_CMD = 2'h1;
  localparam logic [1:0] MODE_FILT = 2'h2;
  localparam logic [1:0] MODE_WIN = 2'h3;
  localparam int ST_COMPLETE = 0;
  localparam int ST_NEAR = 1;
  localparam int ST_ROTATING = 2;
  localparam int ST_CONSISTENT = 3;
  localparam int ST_APPROACH = 4;
  localparam int ST_ZERO = 5;
  localparam int ST_TORQUE = 6;
endpackage : mssj_pkg

// file: hw/mssj_ms_tick.sv
`timescale 1ns/1ns
module mssj_ms_tick
  import mssj_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [31:0] count;
  wire logic at_end = (count == 32'(MS_COUNT - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      count <= at_end ? 32'h00000000 : count + 32'h00000001;
      tick <= at_end;
    end
  end
endmodule : mssj_ms_tick

// file: hw/mssj_judge.sv
`timescale 1ns/1ns
// Contract
// R1 - Two positioning outputs, complete and near, each compare against its own threshold under a shared mode.
// R2 - Mode 0 asserts a positioning output whenever the deviation magnitude is below its threshold.
// R3 - Mode 1 also needs the incoming position command to be zero.
// R4 - Mode 2 also needs the filtered position command to be zero.
// R5 - Mode 3 asserts only after the mode 2 condition held for the whole detection window; the code times one window while either output's condition holds.
// R6 - The detection window is set in milliseconds, default 10.
// R7 - Positioning complete stays asserted for a hold time in milliseconds after asserting, default 100.
// R8 - Rotating asserts when speed magnitude exceeds its threshold, default 20 rpm.
// R9 - Speed consistent asserts when actual speed is within a band of command speed, default 10, range 0 to 100.
// R10 - Speed approaching asserts when speed magnitude reaches its threshold, default 100 rpm.
// R11 - Zero speed asserts when speed magnitude is below its threshold, default 10 rpm.
// R12 - Torque reached asserts once torque reaches threshold plus hysteresis, defaults 100 and 10.
// R13 - Torque reached releases when torque falls below the lower edge of the hysteresis band.
// R14 - Hysteresis is limited to 10 through 20 and acts only together with the threshold.
// R15 - The release level is threshold minus hysteresis so that assert and release differ.
module mssj_judge
  import mssj_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [31:0] pos_deviation,
  input wire logic signed [31:0] pos_command,
  input wire logic signed [31:0] pos_command_filtered,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] speed_command,
  input wire logic signed [15:0] actual_torque,
  output logic positioning_complete,
  output logic positioning_near,
  output logic motor_rotating,
  output logic speed_consistent,
  output logic speed_approaching,
  output logic zero_speed,
  output logic torque_reached
);
  logic [15:0] positioning_judge_mode;
  logic [15:0] positioning_complete_threshold;
  logic [15:0] positioning_near_threshold;
  logic [15:0] positioning_detect_window;
  logic [15:0] positioning_hold_time;
  logic [15:0] rotation_speed_threshold;
  logic [15:0] speed_consistent_threshold;
  logic [15:0] speed_approach_threshold;
  logic [15:0] zero_speed_threshold;
  logic [15:0] torque_reached_threshold;
  logic [15:0] torque_reached_hysteresis;
  logic [15:0] win_count;
  logic [15:0] hold_count;
  logic ms_tick;

  mssj_ms_tick #(
    .MS_COUNT(MS_COUNT)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(ms_tick)
  );

  // Bus decode
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite;
  wire logic [15:0] wdata16 = pwdata[15:0];
  wire logic sel_mode = (paddr == ADDR_MODE);
  wire logic sel_cmp = (paddr == ADDR_CMP_THR);
  wire logic sel_near = (paddr == ADDR_NEAR_THR);
  wire logic sel_win = (paddr == ADDR_WINDOW);
  wire logic sel_hold = (paddr == ADDR_HOLD);
  wire logic sel_rot = (paddr == ADDR_ROT_THR);
  wire logic sel_cons = (paddr == ADDR_CONS_THR);
  wire logic sel_appr = (paddr == ADDR_APPR_THR);
  wire logic sel_zero = (paddr == ADDR_ZERO_THR);
  wire logic sel_tq = (paddr == ADDR_TQ_THR);
  wire logic sel_hys = (paddr == ADDR_TQ_HYS);
  wire logic sel_stat = (paddr == ADDR_STATUS);
  wire logic mapped = sel_mode | sel_cmp | sel_near | sel_win | sel_hold | sel_rot | sel_cons | sel_appr
    | sel_zero | sel_tq | sel_hys | sel_stat;
  wire logic [15:0] cons_clamped = (wdata16 > CONS_MAX) ? CONS_MAX : wdata16;
  wire logic [15:0] hys_clamped = (wdata16 < HYS_MIN) ? HYS_MIN : ((wdata16 > HYS_MAX) ? HYS_MAX : wdata16);
  wire logic [6:0] status_bits;
  assign status_bits[ST_COMPLETE] = positioning_complete;
  assign status_bits[ST_NEAR] = positioning_near;
  assign status_bits[ST_ROTATING] = motor_rotating;
  assign status_bits[ST_CONSISTENT] = speed_consistent;
  assign status_bits[ST_APPROACH] = speed_approaching;
  assign status_bits[ST_ZERO] = zero_speed;
  assign status_bits[ST_TORQUE] = torque_reached;
  wire logic [15:0] rd_word =
    sel_mode ? positioning_judge_mode :
    sel_cmp ? positioning_complete_threshold :
    sel_near ? positioning_near_threshold :
    sel_win ? positioning_detect_window :
    sel_hold ? positioning_hold_time :
    sel_rot ? rotation_speed_threshold :
    sel_cons ? speed_consistent_threshold :
    sel_appr ? speed_approach_threshold :
    sel_zero ? zero_speed_threshold :
    sel_tq ? torque_reached_threshold :
    sel_hys ? torque_reached_hysteresis :
    sel_stat ? {9'h0, status_bits} : 16'h0000;

  // No wait state: ready in the first access phase cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? {16'h0000, rd_word} : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positioning_judge_mode <= RST_MODE;
      positioning_complete_threshold <= RST_CMP_THR;
      positioning_near_threshold <= RST_NEAR_THR;
      positioning_detect_window <= RST_WINDOW; // R6
      positioning_hold_time <= RST_HOLD;
      rotation_speed_threshold <= RST_ROT_THR;
      speed_consistent_threshold <= RST_CONS_THR;
      speed_approach_threshold <= RST_APPR_THR;
      zero_speed_threshold <= RST_ZERO_THR;
      torque_reached_threshold <= RST_TQ_THR;
      torque_reached_hysteresis <= RST_TQ_HYS;
    end else if (wr_en && pready) begin
      if (sel_mode) positioning_judge_mode <= {14'h0, wdata16[1:0]};
      if (sel_cmp) positioning_complete_threshold <= wdata16;
      if (sel_near) positioning_near_threshold <= wdata16;
      if (sel_win) positioning_detect_window <= wdata16;
      if (sel_hold) positioning_hold_time <= wdata16;
      if (sel_rot) rotation_speed_threshold <= wdata16;
      if (sel_cons) speed_consistent_threshold <= cons_clamped; // R9
      if (sel_appr) speed_approach_threshold <= wdata16;
      if (sel_zero) zero_speed_threshold <= wdata16;
      if (sel_tq) torque_reached_threshold <= wdata16;
      if (sel_hys) torque_reached_hysteresis <= hys_clamped; // R14
    end
  end

  // Magnitudes
  wire logic [31:0] dev_abs = pos_deviation[31] ? 32'(-pos_deviation) : 32'(pos_deviation);
  wire logic [15:0] spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
  wire logic signed [16:0] spd_diff = 17'(motor_speed) - 17'(speed_command);
  wire logic [16:0] spd_diff_abs = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);
  wire logic [1:0] mode = positioning_judge_mode[1:0];

  // Positioning qualification
  wire logic cmp_in = dev_abs < {16'h0000, positioning_complete_threshold}; // R1
  wire logic near_in = dev_abs < {16'h0000, positioning_near_threshold}; // R1
  wire logic cmd_zero = (pos_command == 32'sh00000000);
  wire logic filt_zero = (pos_command_filtered == 32'sh00000000);
  wire logic gate =
    (mode == MODE_PLAIN) ? 1'b1 : // R2
    (mode == MODE_CMD) ? cmd_zero : // R3
    filt_zero; // R4
  wire logic cmp_cond = cmp_in && gate;
  wire logic near_cond = near_in && gate;
  wire logic win_done = (win_count >= positioning_detect_window);
  wire logic cmp_qual = (mode == MODE_WIN) ? (cmp_cond && win_done) : cmp_cond; // R5
  wire logic near_qual = (mode == MODE_WIN) ? (near_cond && win_done) : near_cond; // R5
  wire logic hold_active = (hold_count != 16'h0000);

  // Window counts ms while either the complete or the near mode 2 condition holds, restarts when both break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_count <= 16'h0000;
    end else if (!(near_cond || cmp_cond) || mode != MODE_WIN) begin
      win_count <= 16'h0000; // R5
    end else if (ms_tick && !win_done) begin
      win_count <= win_count + 16'h0001; // R6
    end
  end

  // Hold timer loads when complete first asserts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count <= 16'h0000;
    end else if (cmp_qual && !positioning_complete) begin
      hold_count <= positioning_hold_time; // R7
    end else if (ms_tick && hold_active) begin
      hold_count <= hold_count - 16'h0001; // R7
    end
  end

  // Torque band edges
  wire logic [16:0] tq_on = {1'b0, torque_reached_threshold} + {1'b0, torque_reached_hysteresis}; // R12
  wire logic signed [17:0] tq_off = $signed({2'h0, torque_reached_threshold})
    - $signed({2'h0, torque_reached_hysteresis}); // R15
  wire logic signed [17:0] tq_val = 18'(actual_torque);
  wire logic tq_set = tq_val >= $signed({1'b0, tq_on}); // R12
  wire logic tq_clr = tq_val < tq_off; // R13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positioning_complete <= 1'b0;
      positioning_near <= 1'b0;
      motor_rotating <= 1'b0;
      speed_consistent <= 1'b0;
      speed_approaching <= 1'b0;
      zero_speed <= 1'b0;
      torque_reached <= 1'b0;
    end else begin
      positioning_complete <= cmp_qual || (positioning_complete && hold_active); // R7
      positioning_near <= near_qual; // R1
      motor_rotating <= spd_abs > rotation_speed_threshold; // R8
      speed_consistent <= spd_diff_abs <= {1'b0, speed_consistent_threshold}; // R9
      speed_approaching <= spd_abs >= speed_approach_threshold; // R10
      zero_speed <= spd_abs < zero_speed_threshold; // R11
      torque_reached <= tq_set ? 1'b1 : (tq_clr ? 1'b0 : torque_reached); // R13
    end
  end
endmodule : mssj_judge

// file: dv/mssj_judge_checker.sv
`timescale 1ns/1ns
module mssj_judge_checker
  import mssj_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic signed [31:0] pos_deviation,
  input wire logic signed [31:0] pos_command,
  input wire logic signed [31:0] pos_command_filtered,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] speed_command,
  input wire logic signed [15:0] actual_torque,
  input wire logic positioning_complete,
  input wire logic positioning_near,
  input wire logic motor_rotating,
  input wire logic speed_consistent,
  input wire logic speed_approaching,
  input wire logic zero_speed,
  input wire logic torque_reached
);
  // Shadow of the eleven writable registers, one entry per word
  logic [15:0] shadow [11];
  wire wr_hit = psel && penable && pwrite && pready && !pslverr && paddr[5:2] <= 4'hA;
  wire [15:0] spd_abs = motor_speed[15] ? -motor_speed : motor_speed;
  wire [31:0] dev_abs = pos_deviation[31] ? -pos_deviation : pos_deviation;
  wire [15:0] wv = pwdata[15:0];
  // Written value as the register keeps it
  wire [15:0] wr_val = (paddr == ADDR_MODE) ? {14'h0, wv[1:0]} :
    (paddr == ADDR_CONS_THR && wv > CONS_MAX) ? CONS_MAX :
    (paddr == ADDR_TQ_HYS && wv < HYS_MIN) ? HYS_MIN :
    (paddr == ADDR_TQ_HYS && wv > HYS_MAX) ? HYS_MAX : wv;
  wire rot_exp = spd_abs > shadow[5];
  wire appr_exp = spd_abs >= shadow[7];
  wire zero_exp = spd_abs < shadow[8];
  wire near_exp = dev_abs < {16'h0000, shadow[2]};
  wire [16:0] tq_set = {1'h0, shadow[9]} + {1'h0, shadow[10]};
  wire signed [17:0] tq_rel = $signed({2'h0, shadow[9]}) - $signed({2'h0, shadow[10]});
  wire tq_hi = actual_torque >= $signed({1'h0, tq_set});
  wire tq_lo = actual_torque < tq_rel;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= '{RST_MODE, RST_CMP_THR, RST_NEAR_THR, RST_WINDOW, RST_HOLD, RST_ROT_THR,
        RST_CONS_THR, RST_APPR_THR, RST_ZERO_THR, RST_TQ_THR, RST_TQ_HYS};
    end else if (wr_hit) begin
      shadow[paddr[5:2]] <= wr_val;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmp_rise;
    $rose(positioning_complete) && shadow[4] >= 16'h0002;
  endsequence
  sequence s_cmp_stay;
    positioning_complete [*8];
  endsequence
  chk_rot_speed: assert property (presetn |=> motor_rotating == $past(rot_exp))
    else $error("rotating output wrong");
  chk_appr_speed: assert property (presetn |=> speed_approaching == $past(appr_exp))
    else $error("approaching output wrong");
  chk_zero_speed: assert property (presetn |=> zero_speed == $past(zero_exp))
    else $error("zero speed output wrong");
  chk_tq_set: assert property (presetn && tq_hi |=> torque_reached)
    else $error("torque reached not set");
  chk_tq_clear: assert property (tq_lo |=> !torque_reached)
    else $error("torque reached not cleared");
  chk_tq_keep: assert property (!tq_hi && !tq_lo |=> $stable(torque_reached))
    else $error("torque reached changed inside band");
  chk_near_plain: assert property (presetn && shadow[0][1:0] == MODE_PLAIN |=>
    positioning_near == $past(near_exp)) else $error("near output wrong");
  chk_cmp_hold: assert property (s_cmp_rise |-> s_cmp_stay)
    else $error("complete output not held");
endmodule : mssj_judge_checker
bind mssj_judge mssj_judge_checker #(.MS_COUNT(MS_COUNT)) u_chk (.*);

// file: dv/mssj_judge_tb.sv
`timescale 1ns/1ns
module mssj_judge_tb
  import mssj_pkg::*;
;
  typedef struct {
    logic [1:0] mode;
    logic signed [31:0] dev, cmd, filt;
    logic signed [15:0] spd, scmd;
    logic [4:0] exp;
  } mssj_tb_row_t;
  // Expected bits: zero, approaching, consistent, rotating, near
  mssj_tb_row_t rows [8] = '{
    '{2'h0, -32'sh1387, 32'sh5, 32'sh5, 16'sh0, 16'sh0, 5'h15},
    '{2'h0, 32'sh1388, 32'sh5, 32'sh5, 16'sh9, 16'sh0, 5'h14},
    '{2'h1, 32'shA, 32'sh5, 32'sh0, 16'shA, 16'sh0, 5'h04},
    '{2'h1, 32'shA, 32'sh0, 32'sh5, 16'shB, 16'sh0, 5'h01},
    '{2'h2, 32'shA, 32'sh0, 32'sh5, 16'sh14, 16'sh14, 5'h04},
    '{2'h2, 32'shA, 32'sh5, 32'sh0, 16'sh15, 16'sh14, 5'h07},
    '{2'h0, 32'shA, 32'sh0, 32'sh0, -16'sh64, -16'sh64, 5'h0F},
    '{2'h0, 32'shA, 32'sh0, 32'sh0, 16'sh63, -16'sh63, 5'h03}};
  logic [15:0] dflt [11] = '{RST_MODE, RST_CMP_THR, RST_NEAR_THR, RST_WINDOW, RST_HOLD, RST_ROT_THR,
    RST_CONS_THR, RST_APPR_THR, RST_ZERO_THR, RST_TQ_THR, RST_TQ_HYS};
  logic signed [15:0] tqv [4] = '{16'sh6D, 16'sh6E, 16'sh5B, 16'sh59};
  logic tqx [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, positioning_complete, positioning_near, motor_rotating;
  logic speed_consistent, speed_approaching, zero_speed, torque_reached;
  logic signed [31:0] pos_deviation = 32'shFFFF, pos_command = 32'sh0, pos_command_filtered = 32'sh0;
  logic signed [15:0] motor_speed = 16'sh0, speed_command = 16'sh0, actual_torque = 16'sh0;
  int bad_count = 0;
  int samples_checked = 0;
  always #2 pclk = ~pclk;
  mssj_judge #(.MS_COUNT(10)) u_dut (.*);
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [15:0] x);
    apb(1'b0, a, 32'h0);
    check(q, {16'h0000, x});
  endtask : rd
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    step(6);
    presetn <= 1'b1;
    step(1);
    for (int i = 0; i < 11; i++) rd(12'(i * 4), dflt[i]);
    apb(1'b0, 12'h030, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, ADDR_CONS_THR, 32'hC8);
    rd(ADDR_CONS_THR, CONS_MAX);
    apb(1'b1, ADDR_TQ_HYS, 32'h5);
    rd(ADDR_TQ_HYS, HYS_MIN);
    apb(1'b1, ADDR_TQ_HYS, 32'h1E);
    rd(ADDR_TQ_HYS, HYS_MAX);
    apb(1'b1, ADDR_TQ_HYS, 32'hA);
    apb(1'b1, ADDR_CONS_THR, 32'hA);
    apb(1'b1, ADDR_HOLD, 32'h3);
    pos_deviation <= 32'sh31F;
    step(3);
    check(32'(positioning_complete), 32'h1);
    pos_deviation <= 32'sh320;
    step(5);
    check(32'(positioning_complete), 32'h1);
    step(60);
    check(32'(positioning_complete), 32'h0);
    for (int i = 0; i < 4; i++) begin
      actual_torque <= tqv[i];
      step(2);
      check(32'(torque_reached), 32'(tqx[i]));
    end
    foreach (rows[i]) begin
      apb(1'b1, ADDR_MODE, 32'(rows[i].mode));
      pos_deviation <= rows[i].dev;
      pos_command <= rows[i].cmd;
      pos_command_filtered <= rows[i].filt;
      motor_speed <= rows[i].spd;
      speed_command <= rows[i].scmd;
      step(2);
      check(32'({zero_speed, speed_approaching, speed_consistent, motor_rotating, positioning_near}),
        32'(rows[i].exp));
    end
    pos_deviation <= 32'sh1388;
    apb(1'b1, ADDR_WINDOW, 32'h2);
    apb(1'b1, ADDR_MODE, 32'(MODE_WIN));
    pos_deviation <= 32'shA;
    step(5);
    check(32'(positioning_near), 32'h0);
    step(40);
    check(32'(positioning_near), 32'h1);
    rd(ADDR_STATUS, 16'h0007);
    presetn <= 1'b0;
    step(2);
    check(32'({torque_reached, zero_speed, speed_approaching, speed_consistent, motor_rotating,
      positioning_near, positioning_complete}), 32'h0);
    presetn <= 1'b1;
    step(1);
    rd(ADDR_WINDOW, RST_WINDOW);
    step(2);
    check(32'(positioning_complete), 32'h1);
    test_done();
  end
endmodule : mssj_judge_tb
